// *** pkg/quad_decoder_pkg.sv ***
package quad_decoder_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int NUM_AXES   = 3;
  localparam int FILT_DIV_W = 8;
  localparam int FILT_LEN_W = 4;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CHAN_EN   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN    = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR   = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_AXIS_BASE = 12'h010;
  localparam logic [ADDR_W-1:0] AXIS_STRIDE   = 12'h014;
  localparam logic [ADDR_W-1:0] SUB_MODE      = 12'h000;
  localparam logic [ADDR_W-1:0] SUB_QHIT      = 12'h004;
  localparam logic [ADDR_W-1:0] SUB_IHIT      = 12'h008;
  localparam logic [ADDR_W-1:0] SUB_QCNT      = 12'h00C;
  localparam logic [ADDR_W-1:0] SUB_ICNT      = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_FILTER    = 12'h04C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CHAN_EN_STEP   = 4;
  localparam int IRQ_QUAD_BASE  = 0;
  localparam int IRQ_QMODE_BASE = 2;
  localparam int IRQ_INDEX_BASE = 4;
  localparam int IRQ_IMODE_BASE = 6;
  localparam int IRQ_AXIS_STEP  = 8;
  localparam int IRQ_WDOWN_BASE = 24;
  localparam int IRQ_WUP_BASE   = 25;
  localparam int IRQ_WRAP_STEP  = 2;
  localparam int QMODE_LSB      = 0;
  localparam int IMODE_LSB      = 16;
  localparam int FILT_DIV_LSB   = 0;
  localparam int FILT_LEN_LSB   = 8;

  // ----------------------------------------
  // writable bits and reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] CHAN_EN_MASK = 32'h0000_0111;
  localparam logic [DATA_W-1:0] IRQ_EN_MASK  = 32'h3F55_5555;
  localparam logic [DATA_W-1:0] STATUS_MASK  = 32'h3F11_1111;
  localparam logic [DATA_W-1:0] MODE_MASK    = 32'h0003_0003;
  localparam logic [DATA_W-1:0] FILTER_MASK  = 32'h0000_0FFF;
  localparam logic [DATA_W-1:0] CHAN_EN_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] IRQ_EN_RST   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MODE_RST     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] HIT_RST      = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] FILTER_RST   = 32'h0000_0304;

  // ----------------------------------------
  // modes and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {QM_OFF = 2'h0, QM_1X = 2'h1, QM_2X = 2'h2, QM_4X = 2'h3} quad_mode_t;
  typedef enum logic [1:0] {IM_LEVEL = 2'h0, IM_RISE = 2'h1, IM_FALL = 2'h2, IM_BOTH = 2'h3} index_mode_t;

  typedef struct packed {
    logic              enable;
    quad_mode_t        quadMode;
    index_mode_t       indexMode;
    logic              quadOnHit;
    logic              indexOnHit;
    logic [DATA_W-1:0] quadHit;
    logic [DATA_W-1:0] indexHit;
  } axis_cfg_t;

  typedef struct packed {
    logic wrapUp;
    logic wrapDown;
    logic quadEvt;
    logic indexEvt;
  } axis_evt_t;

endpackage : quad_decoder_pkg

// *** design/quad_debounce.sv ***
`timescale 1ns/10ps
module quad_debounce
  import quad_decoder_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  tick,
  input  wire logic [FILT_LEN_W-1:0] len,
  input  wire logic                  pinIn,
  output logic                       level
);

  logic                  syncFirst;
  logic                  syncSecond;
  logic [FILT_LEN_W-1:0] stable;

  // ----------------------------------------
  // synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
    end else if (ce) begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
    end
  end

  // ----------------------------------------
  // filter
  // ----------------------------------------
  // a new level must hold len+1 samples; bounce shorter than that is lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level  <= 1'b0;
      stable <= '0;
    end else if (ce && tick) begin
      if (syncSecond == level) begin
        stable <= '0;
      end else if (stable >= len) begin
        level  <= syncSecond;
        stable <= '0;
      end else begin
        stable <= stable + 1'b1;
      end
    end
  end

endmodule : quad_debounce

// *** design/quad_axis.sv ***
`timescale 1ns/10ps
module quad_axis
  import quad_decoder_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              tick,
  input  axis_cfg_t              cfg,
  input  wire logic              phaseA,
  input  wire logic              phaseB,
  input  wire logic              indexIn,
  output logic      [DATA_W-1:0] quadCount,
  output logic      [DATA_W-1:0] indexCount,
  output axis_evt_t              evt
);

  logic              aPrev;
  logic              bPrev;
  logic              iPrev;
  logic              step;
  logic              up;
  logic              iStep;
  logic [DATA_W-1:0] next_quad;
  logic [DATA_W-1:0] next_index;

  // ----------------------------------------
  // edge decode
  // ----------------------------------------
  always_comb begin
    step = 1'b0;
    up   = 1'b0;
    case (cfg.quadMode)
      QM_1X: begin
        step = phaseA & ~aPrev;
        up   = ~phaseB;
      end
      QM_2X: begin
        step = phaseA ^ aPrev;
        up   = phaseA ^ phaseB;
      end
      QM_4X: begin
        step = (phaseA ^ aPrev) ^ (phaseB ^ bPrev);
        up   = phaseA ^ bPrev;
      end
      default: begin
        step = 1'b0;
        up   = 1'b0;
      end
    endcase
    case (cfg.indexMode)
      IM_LEVEL: iStep = indexIn & tick;
      IM_RISE:  iStep = indexIn & ~iPrev;
      IM_FALL:  iStep = ~indexIn & iPrev;
      default:  iStep = indexIn ^ iPrev;
    endcase
    step       = step & cfg.enable;
    iStep      = iStep & cfg.enable;
    next_quad  = up ? quadCount + 1'b1 : quadCount - 1'b1;
    next_index = indexCount + 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aPrev <= 1'b0;
      bPrev <= 1'b0;
      iPrev <= 1'b0;
    end else if (ce) begin
      aPrev <= phaseA;
      bPrev <= phaseB;
      iPrev <= indexIn;
    end
  end

  // ----------------------------------------
  // counters and events
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quadCount  <= COUNT_RST;
      indexCount <= COUNT_RST;
      evt        <= '0;
    end else if (ce) begin
      if (step) quadCount <= next_quad;
      if (iStep) indexCount <= next_index;
      evt.wrapUp   <= step & up & (&quadCount);
      evt.wrapDown <= step & ~up & (quadCount == '0);
      evt.quadEvt  <= step & (~cfg.quadOnHit | (next_quad == cfg.quadHit));
      evt.indexEvt <= iStep & (~cfg.indexOnHit | (next_index == cfg.indexHit));
    end
  end

endmodule : quad_axis

// *** design/quad_decoder.sv ***
// Operation
// - three axes, each quadrature and index counter
// - quadrature count at 4x, 2x or 1x
// - debounce inputs, registered decoded results
// - sample period and filter length programmable
// - wrap-up interrupt enables at 29,27,25
// - wrap-down interrupt enables at 28,26,24
// - index interrupt mode: change or hit
// - quadrature interrupt mode: change or hit
// - index interrupt enables at 20,12,4
// - quadrature interrupt enables at 16,8,0
// - clear bits 29,27,25 ack wrap-up
// - clear bits 28,26,24 ack wrap-down
// - bit 20 clears z index; reads zero
// - bits 16,12,8,4,0 clear remaining interrupts
// - status register shows conditions per axis
// - 32-bit hit value per axis compared
// - two-bit quadrature mode selects multiplier
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module quad_decoder
  import quad_decoder_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_AXES-1:0] phaseA,
  input  wire logic [NUM_AXES-1:0] phaseB,
  input  wire logic [NUM_AXES-1:0] indexIn,
  output logic                     irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [DATA_W-1:0]     chanEnable;
  logic [DATA_W-1:0]     irqEnable;
  logic [DATA_W-1:0]     irqStatus;
  logic [DATA_W-1:0]     filterCfg;

  logic [DATA_W-1:0]     axisMode   [NUM_AXES];
  logic [DATA_W-1:0]     quadHit    [NUM_AXES];
  logic [DATA_W-1:0]     indexHit   [NUM_AXES];
  logic [DATA_W-1:0]     quadCount  [NUM_AXES];
  logic [DATA_W-1:0]     indexCount [NUM_AXES];
  axis_cfg_t             axisCfg    [NUM_AXES];
  axis_evt_t             axisEvt    [NUM_AXES];

  logic [NUM_AXES-1:0]   fltA;
  logic [NUM_AXES-1:0]   fltB;
  logic [NUM_AXES-1:0]   fltIndex;

  logic [FILT_DIV_W-1:0] divCount;
  logic [FILT_DIV_W-1:0] divLimit;
  logic [FILT_LEN_W-1:0] filtLen;
  logic                  tick;

  logic                  setupPhase;
  logic                  wrEn;
  logic                  rdEn;
  logic                  addrValid;
  logic [DATA_W-1:0]     rdMux;

  logic                  selChan;
  logic                  selIrqEn;
  logic                  selClr;
  logic                  selStat;
  logic                  selFilter;
  logic [NUM_AXES-1:0]   selMode;
  logic [NUM_AXES-1:0]   selQHit;
  logic [NUM_AXES-1:0]   selIHit;
  logic [NUM_AXES-1:0]   selQCnt;
  logic [NUM_AXES-1:0]   selICnt;

  logic [DATA_W-1:0]     setVec;
  logic [DATA_W-1:0]     clrVec;
  logic [DATA_W-1:0]     next_status;

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready     = 1'b1;
  assign setupPhase = psel & ~penable;
  assign wrEn       = psel & penable & pwrite & addrValid & ce;
  assign rdEn       = psel & penable & ~pwrite & addrValid & ce;
  assign pslverr    = psel & penable & ~addrValid;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always_comb begin
    logic [ADDR_W-1:0] base;
    base      = '0;
    selChan   = (paddr == OFF_CHAN_EN);
    selIrqEn  = (paddr == OFF_IRQ_EN);
    selClr    = (paddr == OFF_IRQ_CLR);
    selStat   = (paddr == OFF_IRQ_STAT);
    selFilter = (paddr == OFF_FILTER);

    for (int k = 0; k < NUM_AXES; k++) begin
      base       = ADDR_W'(OFF_AXIS_BASE + AXIS_STRIDE * k);
      selMode[k] = (paddr == ADDR_W'(base + SUB_MODE));
      selQHit[k] = (paddr == ADDR_W'(base + SUB_QHIT));
      selIHit[k] = (paddr == ADDR_W'(base + SUB_IHIT));
      selQCnt[k] = (paddr == ADDR_W'(base + SUB_QCNT));
      selICnt[k] = (paddr == ADDR_W'(base + SUB_ICNT));
    end

    addrValid = selChan | selIrqEn | selClr | selStat | selFilter
              | (|selMode) | (|selQHit) | (|selIHit) | (|selQCnt) | (|selICnt);
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chanEnable <= CHAN_EN_RST;
    end else if (wrEn && selChan) begin
      chanEnable <= pwdata & CHAN_EN_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqEnable <= IRQ_EN_RST;
    end else if (wrEn && selIrqEn) begin
      irqEnable <= pwdata & IRQ_EN_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filterCfg <= FILTER_RST;
    end else if (wrEn && selFilter) begin
      filterCfg <= pwdata & FILTER_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < NUM_AXES; k++) begin
        axisMode[k] <= MODE_RST;
        quadHit[k]  <= HIT_RST;
        indexHit[k] <= HIT_RST;
      end
    end else if (wrEn) begin
      for (int k = 0; k < NUM_AXES; k++) begin
        if (selMode[k]) begin
          axisMode[k] <= pwdata & MODE_MASK;
        end
        if (selQHit[k]) begin
          quadHit[k] <= pwdata;
        end
        if (selIHit[k]) begin
          indexHit[k] <= pwdata;
        end
      end
    end
  end

  // ----------------------------------------
  // sample tick
  // ----------------------------------------
  assign divLimit = filterCfg[FILT_DIV_LSB +: FILT_DIV_W];
  assign filtLen  = filterCfg[FILT_LEN_LSB +: FILT_LEN_W];
  // one shared tick keeps the a and b filters of an axis in step
  assign tick     = (divCount >= divLimit);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      divCount <= '0;
    end else if (ce) begin
      divCount <= tick ? '0 : divCount + 1'b1;
    end
  end

  // ----------------------------------------
  // per-axis configuration
  // ----------------------------------------
  always_comb begin
    for (int k = 0; k < NUM_AXES; k++) begin
      axisCfg[k].enable     = chanEnable[CHAN_EN_STEP * k];
      axisCfg[k].quadMode   = quad_mode_t'(axisMode[k][QMODE_LSB +: 2]);
      axisCfg[k].indexMode  = index_mode_t'(axisMode[k][IMODE_LSB +: 2]);
      axisCfg[k].quadOnHit  = irqEnable[IRQ_QMODE_BASE + IRQ_AXIS_STEP * k];
      axisCfg[k].indexOnHit = irqEnable[IRQ_IMODE_BASE + IRQ_AXIS_STEP * k];
      axisCfg[k].quadHit    = quadHit[k];
      axisCfg[k].indexHit   = indexHit[k];
    end
  end

  // ----------------------------------------
  // filters and axes
  // ----------------------------------------
  for (genvar g = 0; g < NUM_AXES; g++) begin : gAxis
    quad_debounce uFiltA (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (tick),
      .len     (filtLen),
      .pinIn   (phaseA[g]),
      .level   (fltA[g])
    );

    quad_debounce uFiltB (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (tick),
      .len     (filtLen),
      .pinIn   (phaseB[g]),
      .level   (fltB[g])
    );

    quad_debounce uFiltIdx (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (tick),
      .len     (filtLen),
      .pinIn   (indexIn[g]),
      .level   (fltIndex[g])
    );

    quad_axis uAxis (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .ce         (ce),
      .tick       (tick),
      .cfg        (axisCfg[g]),
      .phaseA     (fltA[g]),
      .phaseB     (fltB[g]),
      .indexIn    (fltIndex[g]),
      .quadCount  (quadCount[g]),
      .indexCount (indexCount[g]),
      .evt        (axisEvt[g])
    );
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  always_comb begin
    setVec = '0;
    for (int k = 0; k < NUM_AXES; k++) begin
      setVec[IRQ_WUP_BASE + IRQ_WRAP_STEP * k]   = axisEvt[k].wrapUp;
      setVec[IRQ_WDOWN_BASE + IRQ_WRAP_STEP * k] = axisEvt[k].wrapDown;
      setVec[IRQ_INDEX_BASE + IRQ_AXIS_STEP * k] = axisEvt[k].indexEvt;
      setVec[IRQ_QUAD_BASE + IRQ_AXIS_STEP * k]  = axisEvt[k].quadEvt;
    end

    clrVec = '0;
    if (wrEn && selClr) begin
      clrVec = pwdata & STATUS_MASK;
    end
    // a read clears only what it returned; a bit set since its setup survives
    if (rdEn && selStat) begin
      clrVec = prdata & STATUS_MASK;
    end

    // a new event in the clearing cycle must survive
    next_status = ((irqStatus & ~clrVec) | setVec) & STATUS_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStatus <= '0;
    end else if (ce) begin
      irqStatus <= next_status;
    end
  end

  // enable bits share the status layout; mode bits never meet a status bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(next_status & irqEnable);
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    rdMux = '0;

    if (selChan) begin
      rdMux = chanEnable;
    end
    if (selIrqEn) begin
      rdMux = irqEnable;
    end
    if (selStat) begin
      rdMux = irqStatus;
    end
    if (selFilter) begin
      rdMux = filterCfg;
    end

    for (int k = 0; k < NUM_AXES; k++) begin
      if (selMode[k]) begin
        rdMux = axisMode[k];
      end
      if (selQHit[k]) begin
        rdMux = quadHit[k];
      end
      if (selIHit[k]) begin
        rdMux = indexHit[k];
      end
      if (selQCnt[k]) begin
        rdMux = quadCount[k];
      end
      if (selICnt[k]) begin
        rdMux = indexCount[k];
      end
    end
    if (selClr) begin
      rdMux = '0;
    end
  end

  // captured in setup so the access cycle sees flop data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (ce && setupPhase) begin
      prdata <= pwrite ? '0 : rdMux;
    end
  end

endmodule : quad_decoder

// *** verification/quad_decoder_properties.sv ***
`timescale 1ns/10ps
module quad_decoder_properties
  import quad_decoder_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                ce,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [DATA_W-1:0]   pwdata,
  input wire logic [DATA_W-1:0]   prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NUM_AXES-1:0] phaseA,
  input wire logic [NUM_AXES-1:0] phaseB,
  input wire logic [NUM_AXES-1:0] indexIn,
  input wire logic                irq
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // well past sync plus debounce delay, so no event can still be in flight
  localparam int QUIET = 64;
  logic [DATA_W-1:0] chanShadow;
  logic [DATA_W-1:0] enShadow;
  logic [6:0]        quietCnt;
  logic [8:0]        pinsPrev;
  logic [1:0]        enHist;
  logic              wrTaken;
  logic              badAddr;
  assign wrTaken = psel && penable && pwrite && ce;
  assign badAddr = (paddr[1:0] != 2'h0) || (paddr > OFF_FILTER);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chanShadow <= CHAN_EN_RST;
      enShadow   <= IRQ_EN_RST;
      enHist     <= 2'h0;
    end else begin
      enHist <= {enHist[0], wrTaken && paddr == OFF_IRQ_EN};
      if (wrTaken && paddr == OFF_CHAN_EN) chanShadow <= pwdata & CHAN_EN_MASK;
      if (wrTaken && paddr == OFF_IRQ_EN) enShadow <= pwdata & IRQ_EN_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    pinsPrev <= {phaseA, phaseB, indexIn};
    if (rst || pinsPrev != {phaseA, phaseB, indexIn}) quietCnt <= 7'h00;
    else if (quietCnt != 7'(QUIET)) quietCnt <= quietCnt + 7'h01;
  end

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence rdSetup(logic [ADDR_W-1:0] a);
    psel && !penable && !pwrite && ce && paddr == a;
  endsequence
  sequence wrDone(logic [ADDR_W-1:0] a);
    wrTaken && paddr == a;
  endsequence
  sequence quietNow;
    quietCnt == 7'(QUIET);
  endsequence

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  ready_tied_a: assert property (pready)
    else $error("pready low");
  bus_error_a: assert property (psel && penable |-> pslverr == badAddr)
    else $error("pslverr disagrees with address decode");
  write_data_zero_a: assert property (psel && !penable && pwrite && ce |=> prdata == '0)
    else $error("prdata not zero during write");
  clear_reads_zero_a: assert property (rdSetup(OFF_IRQ_CLR) |=> prdata == '0)
    else $error("clear register reads nonzero");
  chan_readback_a: assert property (rdSetup(OFF_CHAN_EN) |=> prdata == chanShadow)
    else $error("channel enable readback wrong");
  irq_en_readback_a: assert property (rdSetup(OFF_IRQ_EN) |=> prdata == enShadow)
    else $error("interrupt enable readback wrong");
  irq_masked_a: assert property (enShadow == '0 && $past(enShadow) == '0 |-> !irq)
    else $error("irq high with all enables off");
  clear_drops_a: assert property (wrDone(OFF_IRQ_CLR) ##0 quietNow
      ##0 ((pwdata & enShadow & STATUS_MASK) == (enShadow & STATUS_MASK)) |-> ##[1:2] !irq)
    else $error("irq stays high after clearing every enabled bit");
  read_clear_drops_a: assert property (psel && penable && !pwrite && ce
      && paddr == OFF_IRQ_STAT ##0 quietNow |-> ##[1:2] !irq)
    else $error("irq stays high after status read");
  no_spurious_irq_a: assert property (quietNow ##0 (enHist == 2'h0) |-> !$rose(irq))
    else $error("irq rose with no event and no enable change");
endmodule : quad_decoder_properties

bind quad_decoder quad_decoder_properties props_u (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB), .indexIn(indexIn), .irq(irq)
);

// *** verification/quad_encoder_model.sv ***
`timescale 1ns/10ps
module quad_encoder_model
  import quad_decoder_pkg::*;
#(
  parameter int HOLD = 80
) (
  input  wire logic                sys_clk,
  output logic      [NUM_AXES-1:0] phaseA,
  output logic      [NUM_AXES-1:0] phaseB,
  output logic      [NUM_AXES-1:0] indexIn
);
  // ----------------------------------------
  // shaft state
  // ----------------------------------------
  // up means a leads b: 00, 10, 11, 01
  logic [1:0]          pos [0:NUM_AXES-1] = '{default: 2'h0};
  logic [NUM_AXES-1:0] idx  = '0;
  logic [NUM_AXES-1:0] flip = '0;
  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
      phaseA[i] = pos[i][1] ^ pos[i][0] ^ flip[i];
      phaseB[i] = pos[i][1];
    end
  end
  assign indexIn = idx;

  // each level held long enough to pass the debounce filter
  task step(input int k, input logic up);
    @(posedge sys_clk);
    pos[k] <= up ? pos[k] + 2'h1 : pos[k] - 2'h1;
    repeat (HOLD) @(posedge sys_clk);
  endtask : step
  task pulse(input int k);
    @(posedge sys_clk);
    idx[k] <= 1'b1;
    repeat (HOLD) @(posedge sys_clk);
    idx[k] <= 1'b0;
    repeat (HOLD) @(posedge sys_clk);
  endtask : pulse
  // contact bounce, far shorter than the filter length
  task glitch(input int k);
    @(posedge sys_clk);
    flip[k] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    flip[k] <= 1'b0;
    repeat (HOLD) @(posedge sys_clk);
  endtask : glitch
endmodule : quad_encoder_model

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`define CHECK(g, e) begin totalChecks++; if ((g) !== (e)) begin errTotal++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import quad_decoder_pkg::*;
;
  logic                sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq, lastErr;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata, q, c0;
  logic [NUM_AXES-1:0] phaseA, phaseB, indexIn;
  int                  errTotal = 0;
  int                  totalChecks = 0;

  quad_decoder dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phaseA(phaseA), .phaseB(phaseB),
    .indexIn(indexIn), .irq(irq));
  quad_encoder_model enc_u (.sys_clk(sys_clk), .phaseA(phaseA), .phaseB(phaseB),
    .indexIn(indexIn));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, '0);
    `CHECK(q, e)
  endtask : chk
  // irq is registered from next_status, in step with the status bits
  task irqIs(input logic e);
    repeat (3) @(posedge sys_clk);
    `CHECK(irq, e)
  endtask : irqIs
  function logic [ADDR_W-1:0] ax(input int k, input logic [ADDR_W-1:0] s);
    return OFF_AXIS_BASE + AXIS_STRIDE * ADDR_W'(k) + s;
  endfunction : ax
  function logic [DATA_W-1:0] bitAt(input int n);
    return 32'h0000_0001 << n;
  endfunction : bitAt
  task printVerdict;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : printVerdict

  initial begin
    repeat (20000) @(posedge sys_clk);
    errTotal++;
    printVerdict();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {ce, psel, penable, pwrite, lastErr} = 5'h10;
    paddr = '0;
    pwdata = '0;
    q = '0;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    chk(OFF_CHAN_EN, 32'h0000_0000);
    chk(OFF_IRQ_EN, 32'h0000_0000);
    chk(OFF_IRQ_STAT, 32'h0000_0000);
    chk(OFF_FILTER, FILTER_RST);
    apb(1'b1, OFF_CHAN_EN, 32'hFFFF_FFFF);
    chk(OFF_CHAN_EN, 32'h0000_0111);
    apb(1'b1, OFF_IRQ_EN, 32'hFFFF_FFFF);
    chk(OFF_IRQ_EN, 32'h3F55_5555);
    apb(1'b1, OFF_IRQ_EN, 32'h0000_0000);
    apb(1'b1, OFF_IRQ_CLR, 32'hFFFF_FFFF);
    chk(OFF_IRQ_CLR, 32'h0000_0000);
    apb(1'b1, OFF_IRQ_STAT, 32'hFFFF_FFFF);
    chk(OFF_IRQ_STAT, 32'h0000_0000);
    chk(12'h0FC, 32'h0000_0000);
    `CHECK(lastErr, 1'b1)
    // wrap both ways, index and change interrupts on every axis
    for (int k = 0; k < NUM_AXES; k++) begin
      apb(1'b1, ax(k, SUB_MODE), 32'h0000_0003 | (DATA_W'(k + 1) << 16));
      apb(1'b1, OFF_IRQ_EN, bitAt(24 + 2 * k));
      enc_u.step(k, 1'b0);
      chk(ax(k, SUB_QCNT), 32'hFFFF_FFFF);
      irqIs(1'b1);
      apb(1'b1, OFF_IRQ_CLR, bitAt(24 + 2 * k));
      irqIs(1'b0);
      chk(OFF_IRQ_STAT, bitAt(8 * k));
      apb(1'b1, OFF_IRQ_EN, bitAt(25 + 2 * k));
      enc_u.step(k, 1'b1);
      chk(ax(k, SUB_QCNT), 32'h0000_0000);
      irqIs(1'b1);
      apb(1'b1, OFF_IRQ_CLR, bitAt(25 + 2 * k));
      irqIs(1'b0);
      apb(1'b1, OFF_IRQ_EN, bitAt(8 * k + 4));
      irqIs(1'b0);
      enc_u.pulse(k);
      chk(ax(k, SUB_ICNT), (k == 2) ? 32'h0000_0002 : 32'h0000_0001);
      irqIs(1'b1);
      apb(1'b1, OFF_IRQ_CLR, bitAt(8 * k + 4));
      irqIs(1'b0);
      apb(1'b1, OFF_IRQ_EN, bitAt(8 * k));
      irqIs(1'b1);
      apb(1'b1, OFF_IRQ_CLR, bitAt(8 * k));
      irqIs(1'b0);
    end
    // one full cycle per mode: off, 1x, 2x, 4x
    c0 = 32'h0000_0000;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ax(1, SUB_MODE), 32'h0001_0000 | DATA_W'(m));
      repeat (4) enc_u.step(1, 1'b1);
      c0 = c0 + ((m == 3) ? 32'h0000_0004 : DATA_W'(m));
      chk(ax(1, SUB_QCNT), c0);
    end
    enc_u.glitch(1);
    chk(ax(1, SUB_QCNT), c0);
    apb(1'b1, ax(0, SUB_QHIT), 32'h0000_0002);
    apb(1'b1, OFF_IRQ_EN, 32'h0000_0005);
    apb(1'b0, OFF_IRQ_STAT, '0);
    enc_u.step(0, 1'b1);
    irqIs(1'b0);
    enc_u.step(0, 1'b1);
    irqIs(1'b1);
    apb(1'b1, OFF_IRQ_CLR, 32'h0000_0001);
    apb(1'b1, ax(2, SUB_IHIT), 32'h0000_0005);
    apb(1'b1, OFF_IRQ_EN, 32'h0050_0000);
    enc_u.pulse(2);
    irqIs(1'b0);
    enc_u.pulse(2);
    irqIs(1'b1);
    // disabled channel neither counts nor flags
    apb(1'b1, OFF_CHAN_EN, 32'h0000_0110);
    apb(1'b1, OFF_IRQ_EN, 32'h0000_0000);
    apb(1'b0, OFF_IRQ_STAT, '0);
    enc_u.step(0, 1'b1);
    chk(ax(0, SUB_QCNT), 32'h0000_0002);
    chk(OFF_IRQ_STAT, 32'h0000_0000);
    // frozen: this write must not land
    ce <= 1'b0;
    apb(1'b1, OFF_CHAN_EN, 32'h0000_0000);
    ce <= 1'b1;
    chk(OFF_CHAN_EN, 32'h0000_0110);
    printVerdict();
  end
endmodule : testbench
